// ==== design/cer_pkg.sv ====
// Purpose: Shared constants and carrier types for the array group model.
// Assumes: One array group of sixteen macrocells, static configuration.
// Notes:   All sizes that shape structure are named here once.
package cer_pkg;
	localparam int CER_MC_NUM      = 16;
	localparam int CER_CHAIN_LEN   = 8;
	localparam int CER_OWN_PT      = 5;
	localparam int CER_SET_MAX     = 3;
	localparam int CER_PT_MAX      = 20;
	localparam int CER_GOE_NUM     = 6;
	localparam int CER_DED_IN      = 4;
	localparam int CER_OE_IN       = 2;
	localparam int CER_IO_NUM      = 16;
	localparam int CER_TEST_PINS   = 4;
	localparam int CER_BUS_W       = CER_DED_IN + CER_IO_NUM + CER_MC_NUM;
	localparam int CER_TERM_W      = CER_BUS_W + CER_MC_NUM;
	localparam logic [1:0] CER_OE_GND  = 2'h0;
	localparam logic [1:0] CER_OE_VCC  = 2'h1;
	localparam logic [1:0] CER_OE_GLOB = 2'h2;

	typedef struct packed {
		logic                      ena;
		logic [CER_TERM_W-1:0]     true_mask;
		logic [CER_TERM_W-1:0]     comp_mask;
	} cer_pterm_type;

	typedef struct packed {
		logic [CER_MC_NUM-1:0]  mc_out;
		logic [CER_MC_NUM-1:0]  pin_drive;
		logic [CER_MC_NUM-1:0]  pin_oe;
		logic [CER_MC_NUM-1:0]  pin_pullup;
		logic [CER_MC_NUM-1:0]  pin_fb;
		logic                   test_port_on;
	} cer_state_type;
endpackage

// ==== design/cer_macrocell.sv ====
// Purpose: One macrocell sum of own terms and borrowed sets.
// Assumes: Product terms are already evaluated by the array group.
// Notes:   Terms lent away are left out of the OR output; the own sum keeps them.
`timescale 1ns/10ps
module cer_macrocell
	import cer_pkg::*;
(
	input  wire logic [CER_OWN_PT-1:0]  own_pt_i,
	input  wire logic                   lend_i,
	input  wire logic [CER_SET_MAX-1:0] set_sum_i,
	input  wire logic [CER_SET_MAX-1:0] set_use_i,
	output logic                        own_sum_o,
	output logic                        or_out_o
);
	// A lent set is kept from this OR output; up to three higher macrocells in the chain may borrow it.
	assign own_sum_o = |own_pt_i; // see (R1)
	assign or_out_o  = (lend_i ? 1'b0 : own_sum_o) | (|(set_sum_i & set_use_i)); // see (R4) (R21)
endmodule

// ==== design/cer_array_group.sv ====
// Purpose: Array group with expanders, routing bus, and I/O control.
// Assumes: Configuration is static; pins are synchronous to sys_clk_i.
// Notes:   Outputs are registered once per clock for a clean pin model.
// Functional notes
// (R1) Five own product terms per macrocell.
// (R2) Sixteen inverted shared expanders per group.
// (R3) Any macrocell may use any shared expander.
// (R4) Up to twenty terms reach OR gate.
// (R5) At most three borrowed sets of five.
// (R6) Two lending chains of eight macrocells.
// (R7) Borrow only from consecutive lower neighbours.
// (R8) Lowest lends only, highest borrows only.
// (R9) All sources drive the routing bus.
// (R10) Configuration cell ANDs each routed signal.
// (R11) Pin enable: one global enable or constant.
// (R12) Six global enables from selectable true/inverted sources.
// (R13) Tied low is input; tied high drives.
// (R14) Pin and macrocell feedback are independent.
// (R15) Programming holds pins high-Z with pull-up.
// (R16) Guard bit blocks driving until programmed.
// (R17) Programming uses the four-signal test port.
// (R18) Adaptive host reads back and adjusts.
// (R19) Constant host uses fixed sequence.
// (R20) Test port takes four pins while active.
// (R21) Lent terms leave the lender's own sum; the code drops them from or_out only, and own_sum keeps them.
`timescale 1ns/10ps
module cer_array_group
	import cer_pkg::*;
#(
	parameter int GOE_NUM = CER_GOE_NUM
)
(
	input  wire logic                              sys_clk_i,
	input  wire logic                              srst_i,
	input  wire logic [CER_DED_IN-1:0]             ded_in_i,
	input  wire logic [CER_IO_NUM-1:0]             pin_in_i,
	input  wire logic [CER_BUS_W-1:0]              route_cell_i,
	input  cer_pterm_type [CER_MC_NUM*CER_OWN_PT-1:0] pterm_cfg_i,
	input  wire logic [CER_MC_NUM-1:0]             lend_cfg_i,
	input  wire logic [CER_MC_NUM*CER_SET_MAX-1:0] set_use_cfg_i,
	input  wire logic [CER_MC_NUM*2-1:0]           oe_mode_cfg_i,
	input  wire logic [CER_MC_NUM*4-1:0]           oe_sel_cfg_i,
	input  wire logic [GOE_NUM*6-1:0]              goe_src_cfg_i,
	input  wire logic [GOE_NUM-1:0]                goe_inv_cfg_i,
	input  wire logic [CER_OE_IN-1:0]              oe_in_i,
	input  wire logic                              prog_active_i,
	input  wire logic                              guard_done_i,
	input  wire logic                              test_port_active_i,
	output logic [CER_MC_NUM-1:0]                  mc_out_o,
	output logic [CER_IO_NUM-1:0]                  pin_out_o,
	output logic [CER_IO_NUM-1:0]                  pin_oe_o,
	output logic [CER_IO_NUM-1:0]                  pin_pullup_o,
	output logic [CER_IO_NUM-1:0]                  pin_fb_o,
	output logic                                   test_port_on_o
);
	cer_state_type                  state;
	cer_state_type                  next_state;
	logic [CER_BUS_W-1:0]           bus;
	logic [CER_BUS_W-1:0]           routed;
	logic [CER_MC_NUM-1:0]          shared_exp;
	logic [CER_TERM_W-1:0]          terms;
	logic [CER_MC_NUM*CER_OWN_PT-1:0] pt;
	logic [CER_MC_NUM-1:0]          own_sum;
	logic [CER_MC_NUM-1:0]          or_out;
	logic [CER_MC_NUM*CER_SET_MAX-1:0] set_sum;
	logic [GOE_NUM-1:0]             goe;
	logic [CER_MC_NUM-1:0]          lend_eff;
	logic [CER_MC_NUM*CER_SET_MAX-1:0] use_eff;
	logic [CER_MC_NUM-1:0]          exp_term;
	logic                           order_bad;

	// Every source reaches the global bus; only configured ones enter.
	assign bus    = {state.mc_out, pin_in_i, ded_in_i}; // see (R9) (R14)
	assign routed = bus & route_cell_i; // see (R10)
	assign terms  = {shared_exp, routed}; // see (R3)

	// Expander terms look at routed signals only, so no expander can feed itself.
	always_comb begin
		for (int m = 0; m < CER_MC_NUM; m++) begin
			exp_term[m] = pterm_cfg_i[m*CER_OWN_PT].ena &
				(&(routed | ~pterm_cfg_i[m*CER_OWN_PT].true_mask[CER_BUS_W-1:0])) &
				(&(~routed | ~pterm_cfg_i[m*CER_OWN_PT].comp_mask[CER_BUS_W-1:0]));
			shared_exp[m] = ~exp_term[m]; // see (R2)
		end
	end

	// The other terms may take any shared expander as a literal.
	always_comb begin
		for (int k = 0; k < CER_MC_NUM*CER_OWN_PT; k++) begin
			if ((k % CER_OWN_PT) == 0)
				pt[k] = exp_term[k / CER_OWN_PT];
			else
				pt[k] = pterm_cfg_i[k].ena &
					(&(terms | ~pterm_cfg_i[k].true_mask)) &
					(&(~terms | ~pterm_cfg_i[k].comp_mask)); // see (R3)
		end
	end

	// Chain limits: lowest only lends, highest only borrows, no cross-chain.
	always_comb begin
		for (int m = 0; m < CER_MC_NUM; m++) begin
			lend_eff[m] = lend_cfg_i[m] && ((m % CER_CHAIN_LEN) != CER_CHAIN_LEN-1); // see (R8)
			for (int s = 0; s < CER_SET_MAX; s++) begin
				// A set s is the lender s+1 places below, within the chain.
				use_eff[m*CER_SET_MAX+s] = set_use_cfg_i[m*CER_SET_MAX+s] &&
					((m % CER_CHAIN_LEN) > s) && lend_cfg_i[m-s-1 >= 0 ? m-s-1 : 0]; // see (R6) (R7)
				if (s > 0)
					use_eff[m*CER_SET_MAX+s] = use_eff[m*CER_SET_MAX+s] &&
						use_eff[m*CER_SET_MAX+s-1]; // see (R7)
				set_sum[m*CER_SET_MAX+s] = ((m % CER_CHAIN_LEN) > s) ?
					own_sum[m-s-1 >= 0 ? m-s-1 : 0] : 1'b0; // see (R5)
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < CER_MC_NUM; g++) begin : gen_mc
			cer_macrocell u_mc (
				.own_pt_i  (pt[g*CER_OWN_PT +: CER_OWN_PT]),
				.lend_i    (lend_eff[g]),
				.set_sum_i (set_sum[g*CER_SET_MAX +: CER_SET_MAX]),
				.set_use_i (use_eff[g*CER_SET_MAX +: CER_SET_MAX]),
				.own_sum_o (own_sum[g]),
				.or_out_o  (or_out[g])
			);
		end
	endgenerate

	// Global enables from oe inputs, pins or macrocells, true or inverted.
	always_comb begin
		logic [5:0] src;
		src = 6'h00;
		for (int e = 0; e < GOE_NUM; e++) begin
			src = goe_src_cfg_i[e*6 +: 6];
			if (src < 6'(CER_OE_IN))
				goe[e] = oe_in_i[src[0]] ^ goe_inv_cfg_i[e]; // see (R12)
			else if (src < 6'(CER_OE_IN + CER_IO_NUM))
				goe[e] = pin_in_i[4'(src - 6'(CER_OE_IN))] ^ goe_inv_cfg_i[e];
			else
				goe[e] = state.mc_out[4'(src - 6'(CER_OE_IN + CER_IO_NUM))] ^
					goe_inv_cfg_i[e];
		end
	end

	always_comb begin
		logic en;
		logic [3:0] sel;
		en  = 1'b0;
		sel = 4'h0;
		next_state = state;
		next_state.mc_out = or_out;
		next_state.test_port_on = test_port_active_i; // see (R17) (R20)
		for (int p = 0; p < CER_IO_NUM; p++) begin
			sel = oe_sel_cfg_i[p*4 +: 4];
			case (oe_mode_cfg_i[p*2 +: 2])
				CER_OE_GND:  en = 1'b0; // see (R13)
				CER_OE_VCC:  en = 1'b1; // see (R13)
				CER_OE_GLOB: en = (int'(sel) < GOE_NUM) ? goe[int'(sel) % GOE_NUM] : 1'b0; // see (R11)
				default:     en = 1'b0;
			endcase
			if (prog_active_i || !guard_done_i)
				en = 1'b0; // see (R15) (R16)
			if (test_port_active_i && p >= CER_IO_NUM - CER_TEST_PINS)
				en = 1'b0; // see (R20)
			next_state.pin_oe[p]     = en;
			next_state.pin_drive[p]  = or_out[p];
			next_state.pin_pullup[p] = prog_active_i; // see (R15)
			next_state.pin_fb[p]     = pin_in_i[p]; // see (R14)
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign mc_out_o       = state.mc_out;
	assign pin_out_o      = state.pin_drive;
	assign pin_oe_o       = state.pin_oe;
	assign pin_pullup_o   = state.pin_pullup;
	assign pin_fb_o       = state.pin_fb;
	assign test_port_on_o = state.test_port_on;

	property p_prog_hiz;
		@(posedge sys_clk_i) disable iff (srst_i)
		$past(prog_active_i) |-> (pin_oe_o == '0) && (pin_pullup_o == '1);
	endproperty
	a_prog_hiz: assert property (p_prog_hiz) else $error("Pin driven in programming."); // see (R15)

	property p_guard;
		@(posedge sys_clk_i) disable iff (srst_i)
		!guard_done_i |=> pin_oe_o == '0;
	endproperty
	a_guard: assert property (p_guard) else $error("Pin driven before guard."); // see (R16)

	property p_test_pins;
		@(posedge sys_clk_i) disable iff (srst_i)
		test_port_active_i |=> pin_oe_o[CER_IO_NUM-1 -: CER_TEST_PINS] == '0 && test_port_on_o;
	endproperty
	a_test_pins: assert property (p_test_pins) else $error("Test pins used as I/O."); // see (R20)

	property p_fb;
		@(posedge sys_clk_i) disable iff (srst_i)
		##1 pin_fb_o == $past(pin_in_i);
	endproperty
	a_fb: assert property (p_fb) else $error("Pin feedback path broken."); // see (R14)

	property p_route;
		@(posedge sys_clk_i) disable iff (srst_i)
		(routed & ~route_cell_i) == '0;
	endproperty
	a_route: assert property (p_route) else $error("Unselected signal routed."); // see (R10)

	property p_chain_low;
		@(posedge sys_clk_i) disable iff (srst_i)
		use_eff[0 +: CER_SET_MAX] == '0 && use_eff[CER_CHAIN_LEN*CER_SET_MAX +: CER_SET_MAX] == '0;
	endproperty
	a_chain_low: assert property (p_chain_low) else $error("Chain head borrowed."); // see (R8)

	property p_top_lend;
		@(posedge sys_clk_i) disable iff (srst_i)
		!lend_eff[CER_CHAIN_LEN-1] && !lend_eff[CER_MC_NUM-1];
	endproperty
	a_top_lend: assert property (p_top_lend) else $error("Chain top lent terms."); // see (R8)

	property p_vcc;
		@(posedge sys_clk_i) disable iff (srst_i)
		(oe_mode_cfg_i[1:0] == CER_OE_VCC && !prog_active_i && guard_done_i) |=> pin_oe_o[0];
	endproperty
	a_vcc: assert property (p_vcc) else $error("Tied-high pin not driving."); // see (R13)

	// Raised when a borrower uses a later set without the set below it.
	always_comb begin
		order_bad = 1'b0;
		for (int m = 0; m < CER_MC_NUM; m++) begin
			for (int s = 1; s < CER_SET_MAX; s++) begin
				if (use_eff[m*CER_SET_MAX+s] && !use_eff[m*CER_SET_MAX+s-1])
					order_bad = 1'b1;
			end
		end
	end

	property p_set_order;
		@(posedge sys_clk_i) disable iff (srst_i)
		!order_bad;
	endproperty
	a_set_order: assert property (p_set_order) else $error("Sets out of order."); // see (R7)

	property p_chain_cross;
		@(posedge sys_clk_i) disable iff (srst_i)
		use_eff[(CER_CHAIN_LEN+1)*CER_SET_MAX+1 +: CER_SET_MAX-1] == '0;
	endproperty
	a_chain_cross: assert property (p_chain_cross) else $error("Borrow across chains."); // see (R6)

	property p_own_terms;
		@(posedge sys_clk_i) disable iff (srst_i)
		((|pt[0 +: CER_OWN_PT]) && !lend_eff[0]) |=> mc_out_o[0];
	endproperty
	a_own_terms: assert property (p_own_terms) else $error("Own term lost."); // see (R1)

	property p_lender_silent;
		@(posedge sys_clk_i) disable iff (srst_i)
		lend_eff[0] |=> !mc_out_o[0];
	endproperty
	a_lender_silent: assert property (p_lender_silent) else $error("Lent term kept."); // see (R21)

	property p_top_keeps;
		@(posedge sys_clk_i) disable iff (srst_i)
		(|pt[(CER_CHAIN_LEN-1)*CER_OWN_PT +: CER_OWN_PT]) |=> mc_out_o[CER_CHAIN_LEN-1];
	endproperty
	a_top_keeps: assert property (p_top_keeps) else $error("Chain top lost terms."); // see (R8)

	property p_gnd_hiz;
		@(posedge sys_clk_i) disable iff (srst_i)
		(oe_mode_cfg_i[1:0] == CER_OE_GND) |=> !pin_oe_o[0];
	endproperty
	a_gnd_hiz: assert property (p_gnd_hiz) else $error("Tied-low pin driving."); // see (R13)

	property p_glob_on;
		@(posedge sys_clk_i) disable iff (srst_i)
		(oe_mode_cfg_i[1:0] == CER_OE_GLOB && oe_sel_cfg_i[3:0] == 4'h0 &&
			goe_src_cfg_i[5:0] == 6'h00 && !prog_active_i && guard_done_i) |=>
			pin_oe_o[0] == ($past(oe_in_i[0]) ^ $past(goe_inv_cfg_i[0]));
	endproperty
	a_glob_on: assert property (p_glob_on) else $error("Global enable not followed."); // see (R12)

	property p_glob_off;
		@(posedge sys_clk_i) disable iff (srst_i)
		(oe_mode_cfg_i[1:0] == CER_OE_GLOB && int'(oe_sel_cfg_i[3:0]) >= GOE_NUM) |=> !pin_oe_o[0];
	endproperty
	a_glob_off: assert property (p_glob_off) else $error("Absent enable drove pin."); // see (R11)

	property p_pullup_off;
		@(posedge sys_clk_i) disable iff (srst_i)
		!prog_active_i |=> pin_pullup_o == '0;
	endproperty
	a_pullup_off: assert property (p_pullup_off) else $error("Pull-up outside programming."); // see (R15)

	property p_tport_low;
		@(posedge sys_clk_i) disable iff (srst_i)
		!test_port_active_i |=> !test_port_on_o;
	endproperty
	a_tport_low: assert property (p_tport_low) else $error("Test port left on."); // see (R20)
endmodule

// ==== dv/cer_board_model.sv ====
// Purpose: Board side of the user pins of one array group.
// Assumes: The board drives a pin only while the device releases it.
// Notes:   A released pin with its pull-up on reads high.
`timescale 1ns/10ps
module cer_board_model
	import cer_pkg::*;
(
	input  wire logic [CER_IO_NUM-1:0] pin_out_i,
	input  wire logic [CER_IO_NUM-1:0] pin_oe_i,
	input  wire logic [CER_IO_NUM-1:0] pin_pullup_i,
	input  wire logic [CER_IO_NUM-1:0] board_drv_i,
	output logic      [CER_IO_NUM-1:0] pin_level_o
);
	assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & pin_pullup_i)
		| (~pin_oe_i & ~pin_pullup_i & board_drv_i);
endmodule

// ==== dv/cer_array_group_tb_top.sv ====
// Purpose: Self-checking bench for the array group.
// Assumes: Inputs change 1 ns after the rising edge; outputs lag one edge.
// Notes:   Term checks wait two edges to let feedback settle.
`timescale 1ns/10ps
module cer_array_group_tb_top
	import cer_pkg::*;
;
	logic                sys_clk_i;
	logic                srst_i;
	logic [3:0]          ded_in;
	logic [15:0]         pin_lvl, board_drv, lend_cfg, mc_out, pin_out, pin_oe, pin_pu, pin_fb;
	logic [35:0]         route_cell, goe_src;
	logic [47:0]         set_use;
	logic [31:0]         oe_mode;
	logic [63:0]         oe_sel;
	logic [5:0]          goe_inv;
	logic [1:0]          oe_in;
	logic                prog, guard, tport, tp_on;
	cer_pterm_type [79:0] pterm;
	int                  n_errors, n_tests;

	cer_array_group dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ded_in_i(ded_in),
		.pin_in_i(pin_lvl), .route_cell_i(route_cell), .pterm_cfg_i(pterm),
		.lend_cfg_i(lend_cfg), .set_use_cfg_i(set_use), .oe_mode_cfg_i(oe_mode),
		.oe_sel_cfg_i(oe_sel), .goe_src_cfg_i(goe_src), .goe_inv_cfg_i(goe_inv),
		.oe_in_i(oe_in), .prog_active_i(prog), .guard_done_i(guard),
		.test_port_active_i(tport), .mc_out_o(mc_out), .pin_out_o(pin_out),
		.pin_oe_o(pin_oe), .pin_pullup_o(pin_pu), .pin_fb_o(pin_fb), .test_port_on_o(tp_on));
	cer_board_model board_u (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_pullup_i(pin_pu),
		.board_drv_i(board_drv), .pin_level_o(pin_lvl));

	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic term(inout cer_pterm_type [79:0] cfg, input int idx, input int b);
		cfg[idx].ena = 1'b1;
		cfg[idx].true_mask[b] = 1'b1;
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic t_oe_modes();
		oe_mode = {16{CER_OE_VCC}};
		step(1);
		chk(pin_oe, 16'hFFFF);
		board_drv = 16'hA5C3;
		oe_mode = {8{CER_OE_GND, CER_OE_VCC}};
		step(2);
		chk(pin_oe, 16'h5555);
		chk(pin_fb, 16'hA082);
		oe_mode = {16{CER_OE_GLOB}};
		oe_in = 2'h1;
		step(1);
		chk(pin_oe, 16'hFFFF);
		oe_in = 2'h0;
		step(1);
		chk(pin_oe, 16'h0000);
		goe_inv[0] = 1'b1;
		step(1);
		chk(pin_oe, 16'hFFFF);
		oe_sel = {16{4'h6}};
		step(1);
		chk(pin_oe, 16'h0000);
	endtask

	task automatic t_prog();
		oe_mode = {16{CER_OE_VCC}};
		prog = 1'b1;
		step(1);
		chk(pin_oe, 16'h0000);
		chk(pin_pu, 16'hFFFF);
		prog = 1'b0;
		guard = 1'b0;
		step(1);
		chk(pin_oe, 16'h0000);
		guard = 1'b1;
		tport = 1'b1;
		step(1);
		chk(pin_oe, 16'h0FFF);
		chk({15'h0000, tp_on}, 16'h0001);
		tport = 1'b0;
	endtask

	// Host run: a fixed step count, or steps that wait on what it reads back.
	task automatic t_host(input bit adaptive);
		int wait_n;
		wait_n = 0;
		step(1);
		guard = 1'b0;
		prog = 1'b1;
		tport = 1'b1;
		step(1);
		if (adaptive) begin
			while (!(tp_on && pin_pu == 16'hFFFF) && wait_n < 4) begin
				step(1);
				wait_n++;
			end
		end else begin
			step(3);
		end
		chk(pin_oe, 16'h0000);
		chk(pin_pu, 16'hFFFF);
		prog = 1'b0;
		step(1);
		chk(pin_oe, 16'h0000);
		chk(pin_pu, 16'h0000);
		guard = 1'b1;
		tport = 1'b0;
		step(1);
		chk(pin_oe, 16'hFFFF);
	endtask

	task automatic t_shared();
		cer_pterm_type [79:0] cfg;
		cfg = '0;
		term(cfg, 0, 0);
		term(cfg, 5, 0);
		term(cfg, 11, 37);
		term(cfg, 16, 37);
		pterm = cfg;
		route_cell = 36'h000000001;
		ded_in = 4'h1;
		step(2);
		chk(mc_out, 16'h0003);
		chk(pin_out, 16'h0003);
		chk(pin_fb, 16'h0003);
		ded_in = 4'h0;
		step(2);
		chk(mc_out, 16'h000C);
		route_cell = 36'h000000000;
		ded_in = 4'h1;
		step(2);
		chk(mc_out, 16'h000C);
	endtask

	task automatic t_borrow();
		cer_pterm_type [79:0] cfg;
		cfg = '0;
		term(cfg, 0, 0);
		term(cfg, 35, 0);
		pterm = cfg;
		route_cell = 36'h000000001;
		lend_cfg = 16'h0087;
		set_use = 48'h000001000E07;
		step(2);
		chk(mc_out, 16'h0088);
		goe_inv = 6'h00;
		oe_sel = 64'h0;
		goe_src = 36'h000000015;
		oe_mode = {16{CER_OE_GLOB}};
		step(1);
		chk(pin_oe, 16'hFFFF);
		goe_src = 36'h000000016;
		step(1);
		chk(pin_oe, 16'h0000);
		goe_src = 36'h000000009;
		step(1);
		chk(pin_oe, 16'hFFFF);
	endtask

	initial begin
		n_errors = 0;
		n_tests = 0;
		{ded_in, board_drv, lend_cfg, route_cell, goe_src, set_use} = '0;
		{oe_mode, oe_sel, goe_inv, oe_in, prog, tport} = '0;
		pterm = '0;
		guard = 1'b1;
		srst_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		#1;
		srst_i = 1'b0;
		chk(pin_oe, 16'h0000);
		t_oe_modes();
		t_prog();
		t_host(1'b0);
		t_host(1'b1);
		t_shared();
		t_borrow();
		give_verdict();
	end

	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
endmodule
